// ==== rtl/tsd_pkg.sv ====
// Package of constants for the thermal shutdown supervisor
package tsd_pkg;
  // Clock
  localparam int unsigned CLK_HZ = 10_000_000;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_MODE   = 8'h0C;
  // Control field positions
  localparam int CTRL_EXT_WAIT_EN = 0;
  localparam int CTRL_RAISED_THR  = 1;
  localparam int CTRL_RST_DEL_SEL = 2;
  localparam int CTRL_SLEEP_REQ   = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Status field positions
  localparam int ST_CHIP_OT   = 0;
  localparam int ST_REPEAT_OT = 1;
  localparam int ST_OVERVOLT  = 2;
  localparam int ST_SHORT     = 3;
  localparam int ST_RESET_EV  = 4;
  localparam int ST_WIDTH     = 5;
  localparam logic [ST_WIDTH-1:0] ST_RESET   = 5'h00;
  localparam logic [ST_WIDTH-1:0] MASK_RESET = 5'h00;
  // Counting
  localparam logic [4:0] OT_REPEAT_COUNT = 5'h10;
  localparam int unsigned EXT_FACTOR     = 64;
  // Times as printed
  localparam int unsigned COOL_DOWN_US      = 100_000;
  localparam int unsigned LONG_RST_DELAY_MS = 10;
  localparam int unsigned SHORT_RST_DELAY_MS = 2;
  localparam int unsigned RST_FILTER_US     = 10;
  localparam int unsigned OV_FILTER_US      = 64;
  localparam int unsigned SHORT_FILTER_MS   = 2;
  localparam int unsigned RESTART_US        = 10;
  // Cycle counts
  localparam int unsigned COOL_DOWN_CYC   = COOL_DOWN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LONG_RST_CYC    = LONG_RST_DELAY_MS * (CLK_HZ / 1_000);
  localparam int unsigned SHORT_RST_CYC   = SHORT_RST_DELAY_MS * (CLK_HZ / 1_000);
  localparam int unsigned RST_FILTER_CYC  = RST_FILTER_US * (CLK_HZ / 1_000_000);
  localparam int unsigned OV_FILTER_CYC   = OV_FILTER_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SHORT_FILT_CYC  = SHORT_FILTER_MS * (CLK_HZ / 1_000);
  localparam int unsigned RESTART_CYC     = RESTART_US * (CLK_HZ / 1_000_000);
  localparam int TMR_W = 32;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_NORMAL    = 3'b000,
    MODE_FAIL_SAFE = 3'b001,
    MODE_RESTART   = 3'b010,
    MODE_SLEEP_ENT = 3'b011,
    MODE_SLEEP     = 3'b100
  } tsd_mode_e;
endpackage : tsd_pkg

// ==== rtl/tsd_supervisor.sv ====
// Thermal shutdown supervisor with supply filters and reset generator
// Functional notes
// - Chip overtemperature rising edge records an event and enters fail-safe at once.
// - After temperature falls, stay in fail-safe for the cool-down wait.
// - Wait expiry moves through restart to normal without software help.
// - Every chip overtemperature event sets the chip overtemperature flag.
// - Flag clears only by write in normal mode with overtemperature gone.
// - Extended wait enabled and sixteen events give sixty-four times cool-down.
// - Event counter increments on every event while extended wait is enabled, cleared flag or not; the counter here stops at sixteen.
// - Counter reaching sixteen sets repeated flag and extended wait.
// - Extended wait stays while repeated flag set, stops when it clears.
// - Counter zeroes when chip flag or extended-wait enable is cleared.
// - Overtemperature during sleep entry leads to fail-safe, not sleep.
// - Raised threshold bit selects thresholds ten kelvin higher.
// - Reset delay select zero holds reset low ten milliseconds.
// - Reset delay select one uses two millisecond reset delay.
// - Overvoltage reported only after sixty-four microsecond filter.
// - Short filter two milliseconds; short detection only with battery OK.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module tsd_supervisor
  import tsd_pkg::*;
#(
  parameter int unsigned COOL_CYC  = tsd_pkg::COOL_DOWN_CYC,
  parameter int unsigned LRST_CYC  = tsd_pkg::LONG_RST_CYC,
  parameter int unsigned SRST_CYC  = tsd_pkg::SHORT_RST_CYC,
  parameter int unsigned SHORT_CYC = tsd_pkg::SHORT_FILT_CYC
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                chip_overtemp,
  input  wire logic                supply_below_reset,
  input  wire logic                supply_overvolt,
  input  wire logic                battery_ok,
  output logic                     reset_out_n,
  output logic                     raised_thermal_threshold,
  output logic                     fail_safe,
  output logic                     irq
);
  import tsd_pkg::*;

  // Two-flop synchronisers for analog comparator inputs
  logic [3:0] sync1_q, sync2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {battery_ok, supply_overvolt, supply_below_reset, chip_overtemp};
      sync2_q <= sync1_q;
    end
  end
  logic ot_s, uv_s, ov_s, bat_s;
  assign ot_s  = sync2_q[0];
  assign uv_s  = sync2_q[1];
  assign ov_s  = sync2_q[2];
  assign bat_s = sync2_q[3];

  // APB decode, zero wait states
  logic wr_en, rd_en, addr_ok;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                   (paddr == ADDR_MASK) || (paddr == ADDR_MODE);

  logic [31:0] ctrl_q;
  logic [ST_WIDTH-1:0] status_q, mask_q;
  tsd_mode_e mode_q;
  logic ext_en, ext_en_clr;
  assign ext_en     = ctrl_q[CTRL_EXT_WAIT_EN];
  assign ext_en_clr = wr_en && paddr == ADDR_CTRL && ext_en && !pwdata[CTRL_EXT_WAIT_EN];

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= CTRL_RESET;
    else if (wr_en && paddr == ADDR_CTRL) ctrl_q <= {28'h0000000, pwdata[3:0]};
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask_q <= MASK_RESET;
    else if (wr_en && paddr == ADDR_MASK) mask_q <= pwdata[ST_WIDTH-1:0];
  end

  // Chip overtemperature event detect
  logic ot_prev_q, ot_event;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ot_prev_q <= 1'b0;
    else ot_prev_q <= ot_s;
  end
  assign ot_event = ot_s && !ot_prev_q;

  // Supply filters
  logic [TMR_W-1:0] uv_cnt_q, ov_cnt_q, sc_cnt_q;
  logic uv_filt, ov_filt, sc_filt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_cnt_q <= '0;
      ov_cnt_q <= '0;
      sc_cnt_q <= '0;
    end else begin
      uv_cnt_q <= !uv_s ? '0 : (uv_filt ? uv_cnt_q : uv_cnt_q + 1'b1);
      ov_cnt_q <= !ov_s ? '0 : (ov_filt ? ov_cnt_q : ov_cnt_q + 1'b1);
      sc_cnt_q <= !(uv_s && bat_s) ? '0 : (sc_filt ? sc_cnt_q : sc_cnt_q + 1'b1);
    end
  end
  assign uv_filt = uv_cnt_q >= TMR_W'(RST_FILTER_CYC);
  assign ov_filt = ov_cnt_q >= TMR_W'(OV_FILTER_CYC);
  assign sc_filt = sc_cnt_q >= TMR_W'(SHORT_CYC);

  // Status flags: set wins over write-one-to-clear
  logic [ST_WIDTH-1:0] st_set, st_clr;
  logic chip_clr_ok, chip_clr;
  assign chip_clr_ok = (mode_q == MODE_NORMAL) && !ot_s;
  assign st_clr = (wr_en && paddr == ADDR_STATUS) ? pwdata[ST_WIDTH-1:0] : '0;
  assign chip_clr = st_clr[ST_CHIP_OT] && chip_clr_ok && status_q[ST_CHIP_OT];
  logic [4:0] ot_cnt_q;
  logic cnt_hit;
  assign cnt_hit = ext_en && ot_event && (ot_cnt_q == OT_REPEAT_COUNT - 5'h01);
  assign st_set = {uv_filt && !uv_cnt_q[TMR_W-1] && uv_cnt_q == TMR_W'(RST_FILTER_CYC),
                   sc_filt, ov_filt, cnt_hit, ot_event};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_q <= ST_RESET;
    else begin
      status_q[ST_CHIP_OT] <= ot_event || (status_q[ST_CHIP_OT] && !chip_clr);
      status_q[ST_REPEAT_OT] <= st_set[ST_REPEAT_OT] ||
                                (status_q[ST_REPEAT_OT] && !st_clr[ST_REPEAT_OT]);
      status_q[ST_WIDTH-1:ST_OVERVOLT] <= st_set[ST_WIDTH-1:ST_OVERVOLT] |
        (status_q[ST_WIDTH-1:ST_OVERVOLT] & ~st_clr[ST_WIDTH-1:ST_OVERVOLT]);
    end
  end

  // Overtemperature event counter, saturates at sixteen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ot_cnt_q <= 5'h00;
    else if (chip_clr || ext_en_clr) ot_cnt_q <= 5'h00;
    else if (ot_event && ext_en && ot_cnt_q != OT_REPEAT_COUNT)
      ot_cnt_q <= ot_cnt_q + 5'h01;
  end

  // Mode sequencer with cool-down timer
  logic [TMR_W-1:0] tmr_q, cool_len;
  assign cool_len = status_q[ST_REPEAT_OT] ? TMR_W'(COOL_CYC * EXT_FACTOR)
                                           : TMR_W'(COOL_CYC);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_NORMAL;
      tmr_q  <= '0;
    end else begin
      case (mode_q)
        MODE_NORMAL: begin
          tmr_q <= '0;
          if (ot_event) mode_q <= MODE_FAIL_SAFE;
          else if (ctrl_q[CTRL_SLEEP_REQ]) mode_q <= MODE_SLEEP_ENT;
        end
        MODE_SLEEP_ENT: begin
          if (ot_event) mode_q <= MODE_FAIL_SAFE;
          else mode_q <= MODE_SLEEP;
        end
        MODE_SLEEP: begin
          if (ot_event) mode_q <= MODE_FAIL_SAFE;
          else if (!ctrl_q[CTRL_SLEEP_REQ]) mode_q <= MODE_RESTART;
        end
        MODE_FAIL_SAFE: begin
          if (ot_s) tmr_q <= '0;
          else if (tmr_q >= cool_len - 1'b1) begin
            tmr_q  <= '0;
            mode_q <= MODE_RESTART;
          end else tmr_q <= tmr_q + 1'b1;
        end
        MODE_RESTART: begin
          if (ot_event) begin
            mode_q <= MODE_FAIL_SAFE;
            tmr_q  <= '0;
          end else if (tmr_q >= TMR_W'(RESTART_CYC) - 1'b1) begin
            tmr_q  <= '0;
            mode_q <= MODE_NORMAL;
          end else tmr_q <= tmr_q + 1'b1;
        end
        default: mode_q <= MODE_FAIL_SAFE;
      endcase
    end
  end

  // Reset output generator with selectable release delay
  logic [TMR_W-1:0] rd_cnt_q, rd_len;
  logic rst_hold;
  assign rd_len   = ctrl_q[CTRL_RST_DEL_SEL] ? TMR_W'(SRST_CYC) : TMR_W'(LRST_CYC);
  assign rst_hold = uv_filt || mode_q == MODE_FAIL_SAFE || mode_q == MODE_SLEEP;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_cnt_q    <= '0;
      reset_out_n <= 1'b0;
    end else if (rst_hold) begin
      rd_cnt_q    <= '0;
      reset_out_n <= 1'b0;
    end else if (rd_cnt_q < rd_len) begin
      rd_cnt_q    <= rd_cnt_q + 1'b1;
      reset_out_n <= 1'b0;
    end else reset_out_n <= 1'b1;
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raised_thermal_threshold <= 1'b0;
      fail_safe                <= 1'b0;
      irq                      <= 1'b0;
    end else begin
      raised_thermal_threshold <= ctrl_q[CTRL_RAISED_THR];
      fail_safe                <= (mode_q == MODE_FAIL_SAFE);
      irq                      <= |(status_q & mask_q);
    end
  end

  // APB read data and answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_CTRL:   prdata <= ctrl_q;
          ADDR_STATUS: prdata <= {27'h0, status_q};
          ADDR_MASK:   prdata <= {27'h0, mask_q};
          ADDR_MODE:   prdata <= {24'h0, ot_cnt_q, mode_q};
          default:     prdata <= 32'h0000_0000;
        endcase
      end else if (rd_en) prdata <= prdata;
    end
  end

  // Checks
  chk_failsafe_entry: assert property (@(posedge pclk) disable iff (!presetn)
    ot_event && mode_q != MODE_FAIL_SAFE |=> mode_q == MODE_FAIL_SAFE)
    else $error("overtemperature did not enter fail-safe");
  chk_cool_hold: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == MODE_FAIL_SAFE && ot_s |=> mode_q == MODE_FAIL_SAFE)
    else $error("left fail-safe while hot");
  chk_restart_path: assert property (@(posedge pclk) disable iff (!presetn)
    $past(mode_q) == MODE_FAIL_SAFE && mode_q != MODE_FAIL_SAFE |-> mode_q == MODE_RESTART)
    else $error("fail-safe exit skipped restart");
  chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    ot_event |=> status_q[ST_CHIP_OT])
    else $error("chip flag not set");
  chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(status_q[ST_CHIP_OT]) |-> $past(mode_q) == MODE_NORMAL && !$past(ot_s))
    else $error("chip flag cleared illegally");
  chk_counter_zero: assert property (@(posedge pclk) disable iff (!presetn)
    chip_clr || ext_en_clr |=> ot_cnt_q == 5'h00)
    else $error("counter not cleared");
  chk_repeat_set: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_hit |=> status_q[ST_REPEAT_OT] && ot_cnt_q == OT_REPEAT_COUNT)
    else $error("repeat flag missing");
  chk_sleep_abort: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == MODE_SLEEP_ENT && ot_event |=> mode_q == MODE_FAIL_SAFE)
    else $error("sleep entered despite overtemperature");
  chk_reset_low: assert property (@(posedge pclk) disable iff (!presetn)
    uv_filt |=> !reset_out_n)
    else $error("reset not driven low");

  // Named steps of the mode sequence
  sequence s_fs_done;
    mode_q == MODE_FAIL_SAFE && !ot_s && tmr_q >= cool_len - 1'b1;
  endsequence

  sequence s_restart_done;
    mode_q == MODE_RESTART && !ot_event && tmr_q >= TMR_W'(RESTART_CYC) - 1'b1;
  endsequence

  sequence s_sleep_entry;
    mode_q == MODE_NORMAL && ctrl_q[CTRL_SLEEP_REQ] && !ot_event ##1 mode_q == MODE_SLEEP_ENT;
  endsequence

  // Cool cycles seen in fail-safe, counted apart from the sequencer timer
  logic [TMR_W-1:0] cool_seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cool_seen_q <= '0;
    else if (mode_q != MODE_FAIL_SAFE || ot_s) cool_seen_q <= '0;
    else cool_seen_q <= cool_seen_q + 1'b1;
  end

  // Sequencer step checks
  chk_fs_exit: assert property (@(posedge pclk) disable iff (!presetn)
    s_fs_done |=> mode_q == MODE_RESTART)
    else $error("cool-down expiry did not enter restart");

  chk_restart_exit: assert property (@(posedge pclk) disable iff (!presetn)
    s_restart_done |=> mode_q == MODE_NORMAL)
    else $error("restart did not end in normal");

  chk_cool_min: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == MODE_FAIL_SAFE && !ot_s |=> mode_q == MODE_FAIL_SAFE || $past(cool_seen_q) >= cool_len - 1'b1)
    else $error("fail-safe left before cool-down wait");

  chk_sleep_entry_ot: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep_entry ##0 ot_event |=> mode_q == MODE_FAIL_SAFE)
    else $error("sleep entry not turned into fail-safe");

  // Counter, flag and interrupt checks
  chk_count_sat: assert property (@(posedge pclk) disable iff (!presetn)
    ot_cnt_q <= OT_REPEAT_COUNT)
    else $error("event counter beyond sixteen");

  chk_irq_high: assert property (@(posedge pclk) disable iff (!presetn)
    (|(status_q & mask_q)) |=> irq)
    else $error("interrupt missing for unmasked flag");

  chk_irq_low: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(status_q & mask_q)) |=> !irq)
    else $error("interrupt without unmasked flag");

  // Filter, reset output and threshold checks
  chk_ov_filter: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(status_q[ST_OVERVOLT]) |-> $past(ov_cnt_q) >= TMR_W'(OV_FILTER_CYC))
    else $error("overvoltage flagged before filter time");

  chk_short_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !bat_s |=> !sc_filt)
    else $error("short detected with battery low");

  chk_release_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(reset_out_n) |-> $past(rd_cnt_q) >= rd_len)
    else $error("reset released before delay");

  chk_thr_high: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[CTRL_RAISED_THR] |=> raised_thermal_threshold)
    else $error("raised threshold output low");

  chk_thr_low: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q[CTRL_RAISED_THR] |=> !raised_thermal_threshold)
    else $error("raised threshold output high");
endmodule : tsd_supervisor
`default_nettype wire

// ==== testbench/test_tsd_supervisor.sv ====
// Self-checking testbench for the thermal shutdown supervisor
`timescale 1ns/1ns
`default_nettype none
module test_tsd_supervisor;
  import tsd_pkg::*;
  localparam int COOL = 20;
  localparam int LRST = 10;
  localparam int SRST = 5;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic        pready, pslverr, erv, reset_out_n, raised_thermal_threshold, fail_safe, irq;
  logic        chip_overtemp = 1'b0, supply_below_reset = 1'b0, supply_overvolt = 1'b0, battery_ok = 1'b1;
  int          rel_dly, len, err_total = 0, num_checks = 0;
  logic [31:0] rnd;

  tsd_supervisor #(.COOL_CYC(COOL), .LRST_CYC(LRST), .SRST_CYC(SRST), .SHORT_CYC(8)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_overtemp(chip_overtemp), .supply_below_reset(supply_below_reset),
    .supply_overvolt(supply_overvolt), .battery_ok(battery_ok), .reset_out_n(reset_out_n),
    .raised_thermal_threshold(raised_thermal_threshold), .fail_safe(fail_safe), .irq(irq));
  tsd_mcu_model i_mcu (.pclk(pclk), .supply_low(supply_below_reset), .reset_out_n(reset_out_n),
    .rel_dly(rel_dly));

  // Clock of 100 ns period
  always #50 pclk = ~pclk;

  // Compare a design value
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk_val

  // Compare a measured cycle count against a window
  task automatic chk_range(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
      err_total++;
    end
  endtask : chk_range

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Overtemperature pulse, optional clear attempt in fail-safe, returns fail-safe time after cooling
  task automatic ot_event(input bit try_clr, input logic [31:0] cv, output int fs_len);
    int n;
    chip_overtemp <= 1'b1;
    n = 0;
    while (fail_safe !== 1'b1 && n < 10) begin
      @(posedge pclk);
      n++;
    end
    chk_val("fail-safe entry", 32'h1, {31'h0, fail_safe});
    if (try_clr) begin
      apb(1'b1, ADDR_STATUS, 32'h1);
      apb(1'b1, ADDR_CTRL, cv);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk_val("flag kept in fail-safe", 32'h1, rdv & 32'h1);
    end
    repeat ($urandom_range(1, 4)) @(posedge pclk);
    chip_overtemp <= 1'b0;
    fs_len = 0;
    while (fail_safe !== 1'b0 && fs_len < 2000) begin
      @(posedge pclk);
      fs_len++;
    end
    repeat (110) @(posedge pclk);
  endtask : ot_event

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("Checks made %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    give_verdict();
  end

  // Main sequence
  initial begin
    rdv = $urandom(98977);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and the unmapped address
    apb(1'b0, ADDR_CTRL, 32'h0);   chk_val("ctrl reset", CTRL_RESET, rdv);
    apb(1'b0, ADDR_MASK, 32'h0);   chk_val("mask reset", 32'(MASK_RESET), rdv);
    apb(1'b0, 8'h10, 32'h0);       chk_val("unmapped error", 32'h1, {31'h0, erv});
    chk_val("unmapped data", 32'h0, rdv);
    repeat (LRST + 20) @(posedge pclk);
    apb(1'b1, ADDR_STATUS, 32'h1F);
    apb(1'b1, ADDR_MASK, 32'h1F);
    repeat (3) @(posedge pclk);
    chk_val("irq idle", 32'h0, {31'h0, irq});
    // Event, ignored clear, cool-down, return to normal, clear in normal
    ot_event(1'b1, 32'h0, len);
    chk_range("cool-down", COOL, COOL + 8, len);
    apb(1'b0, ADDR_MODE, 32'h0);   chk_val("mode normal", 32'(MODE_NORMAL), rdv & 32'h7);
    apb(1'b0, ADDR_STATUS, 32'h0); chk_val("chip flag", 32'h1, rdv & 32'h1);
    chk_val("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, ADDR_STATUS, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0); chk_val("chip flag cleared", 32'h0, rdv & 32'h1);
    chk_val("irq cleared", 32'h0, {31'h0, irq});
    // Sixteen events with extended wait enabled, flag left set
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_EXT_WAIT_EN);
    for (int i = 0; i < 16; i++) ot_event(1'b0, 32'h0, len);
    apb(1'b0, ADDR_MODE, 32'h0);   chk_val("event count", 32'(OT_REPEAT_COUNT), (rdv >> 3) & 32'h1F);
    apb(1'b0, ADDR_STATUS, 32'h0); chk_val("repeat flag", 32'h1, (rdv >> ST_REPEAT_OT) & 32'h1);
    ot_event(1'b0, 32'h0, len);
    chk_range("extended wait", COOL * EXT_FACTOR, COOL * EXT_FACTOR + 8, len);
    apb(1'b1, ADDR_STATUS, 32'h1);
    apb(1'b0, ADDR_MODE, 32'h0);   chk_val("count zeroed", 32'h0, (rdv >> 3) & 32'h1F);
    apb(1'b1, ADDR_STATUS, 32'h2);
    ot_event(1'b0, 32'h0, len);
    chk_range("wait after repeat clear", COOL, COOL + 8, len);
    // Overtemperature timed to land while the sequencer is in sleep entry
    fork
      begin
        repeat (2) @(posedge pclk);
        chip_overtemp <= 1'b1;
      end
      apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_SLEEP_REQ);
    join
    ot_event(1'b1, 32'h0, len);
    apb(1'b0, ADDR_MODE, 32'h0);   chk_val("normal after sleep abort", 32'(MODE_NORMAL), rdv & 32'h7);
    // Random control writes and the raised threshold output, one cycle behind the register
    for (int i = 0; i < 6; i++) begin
      rnd = $urandom & 32'h6;
      apb(1'b1, ADDR_CTRL, rnd);
      repeat (2) @(posedge pclk);
      chk_val("raised threshold", {31'h0, rnd[CTRL_RAISED_THR]}, {31'h0, raised_thermal_threshold});
    end
    // Supply dips: reset filter, release delay per select, short detection per battery
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, ADDR_CTRL, 32'(s) << CTRL_RST_DEL_SEL);
      apb(1'b1, ADDR_STATUS, 32'h1F);
      battery_ok <= (s == 0);
      supply_below_reset <= 1'b1;
      repeat (5) @(posedge pclk);
      chk_val("reset filtered", 32'h1, {31'h0, reset_out_n});
      repeat (RST_FILTER_CYC + 10) @(posedge pclk);
      chk_val("reset asserted", 32'h0, {31'h0, reset_out_n});
      supply_below_reset <= 1'b0;
      repeat (LRST + 20) @(posedge pclk);
      chk_range("release delay", (s == 0) ? LRST : SRST, ((s == 0) ? LRST : SRST) + 4, rel_dly);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk_val("short flag", (s == 0) ? 32'h1 : 32'h0, (rdv >> ST_SHORT) & 32'h1);
    end
    // Overvoltage shorter than the filter, then longer
    supply_overvolt <= 1'b1;
    repeat ($urandom_range(100, 600)) @(posedge pclk);
    supply_overvolt <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0); chk_val("short overvoltage", 32'h0, (rdv >> ST_OVERVOLT) & 32'h1);
    supply_overvolt <= 1'b1;
    repeat (OV_FILTER_CYC + 10) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0); chk_val("overvoltage", 32'h1, (rdv >> ST_OVERVOLT) & 32'h1);
    give_verdict();
  end
endmodule : test_tsd_supervisor
`default_nettype wire

// ==== testbench/tsd_mcu_model.sv ====
// Microcontroller side model that receives the reset line
`timescale 1ns/1ns
`default_nettype none
module tsd_mcu_model (
  input  wire logic pclk,
  input  wire logic supply_low,
  input  wire logic reset_out_n,
  output int        rel_dly
);
  int cnt = 0;
  initial rel_dly = 0;
  // Count held-reset cycles once the supply is good, latch on release
  always @(posedge pclk) begin
    if (supply_low) begin
      cnt = 0;
    end else if (reset_out_n !== 1'b1) begin
      cnt = cnt + 1;
    end else if (cnt != 0) begin
      rel_dly = cnt;
      cnt = 0;
    end
  end
endmodule : tsd_mcu_model
`default_nettype wire
